// File: lmfc_align_pkg.sv
package lmfc_align_pkg;
   localparam int          LANES           = 4;
   localparam int          LANE_W          = 32;
   localparam int          FIFO_DEPTH      = 32;
   localparam logic [11:0] ADDR_LATENCY    = 12'h302;
   localparam logic [11:0] ADDR_FIXED      = 12'h304;
   localparam logic [11:0] ADDR_VAR        = 12'h306;
   localparam logic [7:0]  RESET_FIXED     = 8'h00;
   localparam logic [7:0]  RESET_VAR       = 8'h0C;
   localparam logic [7:0]  MAX_VAR         = 8'h0C;
   localparam logic [4:0]  CYCLES_MF_F2    = 5'h10;
   localparam logic [4:0]  CYCLES_MF_F1    = 5'h08;
   localparam int          PCLK_BYTES      = 4;
   localparam real         CLK_PERIOD_NS   = 10.0;

   typedef struct packed {
      logic [LANES*LANE_W-1:0] data;
   } lane_word_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } reg_req_s;

   typedef enum logic [1:0] {
      ALIGN_IDLE,
      ALIGN_WAIT_EDGE,
      ALIGN_RUN
   } align_state_e;
endpackage : lmfc_align_pkg

// File: lane_fifo.sv
module lane_fifo #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 32
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_n_in,
   input  wire logic             flush_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic [WIDTH-1:0]      out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             push;
   logic             pop;
   logic             full;
   logic             empty;

   always_comb begin
      full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
      empty       = (wr_ptr == rd_ptr);
      push        = in_valid_in && !full;
      pop         = out_ready_in && !empty;
      next_wr_ptr = flush_in ? '0 : wr_ptr + (AW+1)'(push);
      next_rd_ptr = flush_in ? '0 : rd_ptr + (AW+1)'(pop);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end

   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem[rd_ptr[AW-1:0]];
endmodule : lane_fifo

// File: lmfc_delay_receive_buffer_align.sv
// Operation
// - all lanes read within one multiframe period
// - local multiframe clock delayed by fixed offset
// - release data variation cycles after local boundary
// - buffer hold supports 0 through 12 cycles
// - both delays counted in processing cycles
// - processing clock is byte rate over four
// - read-only latency from sysref-aligned multiframe clock (not the delayed local one) to data
// - latency readback wraps modulo multiframe length
// - multiframe is 16 cycles f=2, 8 f=1
// - align multiframe clock to chosen sysref edge
module lmfc_delay_receive_buffer_align #(
   parameter int LANES      = lmfc_align_pkg::LANES,
   parameter int LANE_W     = lmfc_align_pkg::LANE_W,
   parameter int FIFO_DEPTH = lmfc_align_pkg::FIFO_DEPTH
) (
   input  wire logic                    mclk_in,
   input  wire logic                    rst_n_in,
   input  wire lmfc_align_pkg::reg_req_s reg_req_in,
   output logic [7:0]                   reg_rdata_out,
   input  wire logic                    two_octets_per_frame_in,
   input  wire logic                    single_shot_align_arm_in,
   input  wire logic [7:0]              sysref_skip_count_in,
   input  wire logic                    sysref_in,
   input  wire logic [LANES*LANE_W-1:0] lane_data_in,
   input  wire logic                    lane_valid_in,
   input  wire logic                    first_data_in,
   output logic                         lane_ready_out,
   output logic [LANES*LANE_W-1:0]      sample_data_out,
   output logic                         sample_valid_out,
   output logic                         aligned_out
);
   localparam int W = LANES*LANE_W;

   logic [7:0]  multiframe_fixed_offset;
   logic [7:0]  multiframe_variation_allowance;
   logic [7:0]  measured_link_latency;
   logic [4:0]  proc_cycles_per_multiframe;
   logic [4:0]  sysref_phase;
   logic [4:0]  local_phase;
   logic [3:0]  hold_cnt;
   logic        sysref_d;
   logic        releasing;
   logic        latency_caught;
   logic [7:0]  skip_left;
   lmfc_align_pkg::align_state_e state;

   logic [7:0]  next_fixed;
   logic [7:0]  next_var;
   logic [7:0]  next_latency;
   logic [4:0]  next_sysref_phase;
   logic [4:0]  next_local_phase;
   logic [3:0]  next_hold_cnt;
   logic        next_releasing;
   logic        next_latency_caught;
   logic [7:0]  next_skip_left;
   logic [7:0]  next_rdata;
   logic        next_sample_valid;
   logic [W-1:0] next_sample_data;
   lmfc_align_pkg::align_state_e next_state;

   logic [W-1:0] fifo_data;
   logic        fifo_valid;
   logic        fifo_pop;
   logic        fifo_flush;
   logic        sysref_rise;
   logic        local_boundary;
   logic [7:0]  hold_eff;
   logic [5:0]  sum_phase;

   assign proc_cycles_per_multiframe = two_octets_per_frame_in
      ? lmfc_align_pkg::CYCLES_MF_F2 : lmfc_align_pkg::CYCLES_MF_F1;
   assign sysref_rise    = sysref_in && !sysref_d;
   assign local_boundary = (state == lmfc_align_pkg::ALIGN_RUN) && (local_phase == 5'h00);
   assign fifo_flush     = (state != lmfc_align_pkg::ALIGN_RUN);
   assign hold_eff = (multiframe_variation_allowance > lmfc_align_pkg::MAX_VAR)
                   ? lmfc_align_pkg::MAX_VAR : multiframe_variation_allowance;
   assign fifo_pop  = releasing && fifo_valid;

   lane_fifo #(
      .WIDTH (W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_in       (mclk_in),
      .rst_n_in      (rst_n_in),
      .flush_in      (fifo_flush),
      .in_data_in    (lane_data_in),
      .in_valid_in   (lane_valid_in),
      .in_ready_out  (lane_ready_out),
      .out_data_out  (fifo_data),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_pop)
   );

   always_comb begin
      next_fixed          = multiframe_fixed_offset;
      next_var            = multiframe_variation_allowance;
      next_state          = state;
      next_skip_left      = skip_left;
      next_sysref_phase   = sysref_phase;
      next_local_phase    = local_phase;
      next_hold_cnt       = hold_cnt;
      next_releasing      = releasing;
      next_latency        = measured_link_latency;
      next_latency_caught = latency_caught;
      sum_phase           = 6'h00;
      if (reg_req_in.wr) begin
         if (reg_req_in.addr == lmfc_align_pkg::ADDR_FIXED) begin
            next_fixed = reg_req_in.wdata;
         end
         if (reg_req_in.addr == lmfc_align_pkg::ADDR_VAR) begin
            next_var = reg_req_in.wdata;
         end
      end
      case (state)
         lmfc_align_pkg::ALIGN_IDLE: begin
            if (single_shot_align_arm_in) begin
               next_state     = lmfc_align_pkg::ALIGN_WAIT_EDGE;
               next_skip_left = sysref_skip_count_in;
            end
         end
         lmfc_align_pkg::ALIGN_WAIT_EDGE: begin
            if (sysref_rise) begin
               if (skip_left == 8'h00) begin
                  next_state          = lmfc_align_pkg::ALIGN_RUN;
                  next_sysref_phase   = 5'h01;
                  next_hold_cnt       = 4'h0;
                  sum_phase           = 6'h21 - {1'b0, proc_cycles_per_multiframe}
                                        - {1'b0, multiframe_fixed_offset[4:0]};
                  next_local_phase    = 5'(sum_phase % {1'b0, proc_cycles_per_multiframe});
                  next_releasing      = 1'b0;
                  next_latency_caught = 1'b0;
               end else begin
                  next_skip_left = skip_left - 8'h01;
               end
            end
         end
         lmfc_align_pkg::ALIGN_RUN: begin
            if (single_shot_align_arm_in) begin
               next_state     = lmfc_align_pkg::ALIGN_WAIT_EDGE;
               next_skip_left = sysref_skip_count_in;
               next_releasing = 1'b0;
            end
            next_sysref_phase = (sysref_phase + 5'h01 >= proc_cycles_per_multiframe)
                              ? 5'h00 : sysref_phase + 5'h01;
            next_local_phase  = (local_phase + 5'h01 >= proc_cycles_per_multiframe)
                              ? 5'h00 : local_phase + 5'h01;
            if (local_boundary && !releasing && hold_cnt == 4'h0) begin
               next_hold_cnt = hold_eff[3:0];
               if (hold_eff == 8'h00) begin
                  next_releasing = 1'b1;
               end
            end else if (hold_cnt != 4'h0 && !releasing) begin
               next_hold_cnt = hold_cnt - 4'h1;
               if (hold_cnt == 4'h1) begin
                  next_releasing = 1'b1;
               end
            end
            if (first_data_in && !latency_caught) begin
               next_latency        = {3'h0, sysref_phase};
               next_latency_caught = 1'b1;
            end
         end
         default: begin
            next_state = lmfc_align_pkg::ALIGN_IDLE;
         end
      endcase
      next_sample_valid = fifo_pop;
      next_sample_data  = fifo_pop ? fifo_data : sample_data_out;
      case (reg_req_in.addr)
         lmfc_align_pkg::ADDR_LATENCY: next_rdata = measured_link_latency;
         lmfc_align_pkg::ADDR_FIXED:   next_rdata = multiframe_fixed_offset;
         lmfc_align_pkg::ADDR_VAR:     next_rdata = multiframe_variation_allowance;
         default:                      next_rdata = 8'h00;
      endcase
      if (!reg_req_in.rd) begin
         next_rdata = reg_rdata_out;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         multiframe_fixed_offset        <= lmfc_align_pkg::RESET_FIXED;
         multiframe_variation_allowance <= lmfc_align_pkg::RESET_VAR;
         measured_link_latency          <= 8'h00;
         state                          <= lmfc_align_pkg::ALIGN_IDLE;
         skip_left                      <= 8'h00;
         sysref_phase                   <= 5'h00;
         local_phase                    <= 5'h00;
         hold_cnt                       <= 4'h0;
         releasing                      <= 1'b0;
         latency_caught                 <= 1'b0;
         sysref_d                       <= 1'b0;
         reg_rdata_out                  <= 8'h00;
         sample_valid_out               <= 1'b0;
         sample_data_out                <= '0;
         aligned_out                    <= 1'b0;
      end else begin
         multiframe_fixed_offset        <= next_fixed;
         multiframe_variation_allowance <= next_var;
         measured_link_latency          <= next_latency;
         state                          <= next_state;
         skip_left                      <= next_skip_left;
         sysref_phase                   <= next_sysref_phase;
         local_phase                    <= next_local_phase;
         hold_cnt                       <= next_hold_cnt;
         releasing                      <= next_releasing;
         latency_caught                 <= next_latency_caught;
         sysref_d                       <= sysref_in;
         reg_rdata_out                  <= next_rdata;
         sample_valid_out               <= next_sample_valid;
         sample_data_out                <= next_sample_data;
         aligned_out                    <= (next_state == lmfc_align_pkg::ALIGN_RUN);
      end
   end
endmodule : lmfc_delay_receive_buffer_align

// File: lmfc_align_checker.sv
module lmfc_align_checker (
   input wire logic                     mclk_in,
   input wire logic                     rst_n_in,
   input wire lmfc_align_pkg::reg_req_s reg_req_in,
   input wire logic [7:0]               reg_rdata_out,
   input wire logic                     single_shot_align_arm_in,
   input wire logic                     sysref_in,
   input wire logic                     lane_ready_out,
   input wire logic                     sample_valid_out,
   input wire logic                     aligned_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   AST_RD_FIXED: assert property (reg_req_in.wr && reg_req_in.addr == 12'h304 ##1
      reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == 12'h304
      |=> reg_rdata_out == $past(reg_req_in.wdata, 2)) else $error("fixed readback wrong");
   AST_RD_VAR: assert property (reg_req_in.wr && reg_req_in.addr == 12'h306
      && reg_req_in.wdata <= 8'h0C ##1 reg_req_in.rd && !reg_req_in.wr && reg_req_in.addr == 12'h306
      |=> reg_rdata_out == $past(reg_req_in.wdata, 2)) else $error("variation readback wrong");
   AST_UNMAPPED: assert property (reg_req_in.rd && !(reg_req_in.addr inside
      {12'h302, 12'h304, 12'h306}) |=> reg_rdata_out == 8'h00) else $error("unmapped read not 0");
   AST_RD_HOLD: assert property (!$past(reg_req_in.rd) |-> $stable(reg_rdata_out))
      else $error("read data moved without read");
   AST_ALIGN_EDGE: assert property ($rose(aligned_out) |-> $past(sysref_in)
      && !$past(sysref_in, 2)) else $error("alignment not on sysref edge");
   AST_ARM_DROPS: assert property (single_shot_align_arm_in |=> !aligned_out)
      else $error("aligned while armed");
   AST_HOLD_DATA: assert property (!aligned_out && !$past(aligned_out)
      && !$past(aligned_out, 2) |-> !sample_valid_out) else $error("data out while unaligned");
   AST_FLUSH_READY: assert property (!aligned_out && !$past(aligned_out)
      |-> lane_ready_out) else $error("buffer not flushed while unaligned");
   COV_ALIGN: cover property ($rose(aligned_out));
   COV_DATA: cover property (sample_valid_out ##1 sample_valid_out);
   COV_LAT: cover property (reg_req_in.rd && reg_req_in.addr == 12'h302);
endmodule : lmfc_align_checker

// File: lane_tx_model.sv
module lane_tx_model #(
   parameter int WORDS = 24
) (
   input wire logic          mclk_in,
   input wire logic          rst_n_in,
   input wire logic          start_in,
   input wire logic          slow_in,
   input wire logic          ready_in,
   output logic [127:0]      data_out,
   output logic              valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sent;
   logic [7:0] idx;
   logic       run;
   logic       go;
   assign idx = sent + {7'h00, valid_out && ready_in};
   assign go  = (run || start_in) && idx < 8'(WORDS) && !(slow_in && valid_out);
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sent      <= 8'h00;
         run       <= 1'b0;
         valid_out <= 1'b0;
         data_out  <= '0;
      end else begin
         if (start_in) run <= 1'b1;
         sent <= idx;
         if (!valid_out || ready_in) begin // word held until taken
            valid_out <= go;
            data_out  <= go ? {4{24'hA50000, idx}} : ~data_out;
         end
      end
   end
endmodule : lane_tx_model

// File: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WORDS = 24;
   logic mclk_in = 1'b0, rst_n_in = 1'b0, sysref_in = 1'b0, first_data_in = 1'b0;
   logic two_octets_per_frame_in = 1'b0, single_shot_align_arm_in = 1'b0, start = 1'b0;
   logic slow = 1'b0, lane_valid_in, lane_ready_out, sample_valid_out, aligned_out;
   logic [7:0]               sysref_skip_count_in = 8'h00, reg_rdata_out;
   logic [127:0]             lane_data_in, sample_data_out;
   lmfc_align_pkg::reg_req_s reg_req_in = '0;
   logic [31:0]              lfsr = 32'h3913;
   int err_total = 0, check_count = 0, rx_idx = 0, mf, fix, vr, k, cyc = 0, t0 = 0;
   lmfc_delay_receive_buffer_align dut (
      .mclk_in                  (mclk_in),
      .rst_n_in                 (rst_n_in),
      .reg_req_in               (reg_req_in),
      .reg_rdata_out            (reg_rdata_out),
      .two_octets_per_frame_in  (two_octets_per_frame_in),
      .single_shot_align_arm_in (single_shot_align_arm_in),
      .sysref_skip_count_in     (sysref_skip_count_in),
      .sysref_in                (sysref_in),
      .lane_data_in             (lane_data_in),
      .lane_valid_in            (lane_valid_in),
      .first_data_in            (first_data_in),
      .lane_ready_out           (lane_ready_out),
      .sample_data_out          (sample_data_out),
      .sample_valid_out         (sample_valid_out),
      .aligned_out              (aligned_out)
   );
   lane_tx_model #(.WORDS(WORDS)) tx (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start),
      .slow_in(slow), .ready_in(lane_ready_out), .data_out(lane_data_in), .valid_out(lane_valid_in));
   always #5 mclk_in = ~mclk_in;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic logic [127:0] exp_word(input int n);
      return {4{24'hA50000, n[7:0]}};
   endfunction : exp_word
   function automatic logic [7:0] exp_lat(input int d, input int m);
      return 8'(d % m);
   endfunction : exp_lat
   function automatic logic [7:0] exp_first(input int f, input int v, input int m);
      return 8'((f == 0 ? m : f) + v + 2);
   endfunction : exp_first
   task automatic step();
      @(posedge mclk_in);
      #1;
   endtask : step
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmp128(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp128
   task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
      reg_req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      step();
   endtask : reg_wr
   task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
      reg_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      step();
      cmp8(reg_rdata_out, exp);
   endtask : reg_rd
   task automatic give_verdict();
      $display("mismatches=%0d comparisons=%0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   always @(posedge mclk_in) cyc <= cyc + 1;
   always @(negedge mclk_in) begin
      if (rst_n_in && sample_valid_out) begin
         if (rx_idx == 0) cmp8(8'(cyc - t0), exp_first(fix, vr, mf));
         cmp128(sample_data_out, exp_word(rx_idx));
         rx_idx++;
      end
   end
   initial begin
      #60us;
      err_total++;
      give_verdict();
   end
   initial begin
      for (int run = 0; run < 2; run++) begin
         rst_n_in = 1'b0;
         sysref_in = 1'b0;
         reg_req_in = '0;
         rx_idx = 0;
         slow = run[0];
         two_octets_per_frame_in = run[0];
         sysref_skip_count_in = 8'(run);
         repeat (3) step();
         rst_n_in = 1'b1;
         mf = run ? 16 : 8;
         lfsr = lfsr_next(lfsr);
         fix = run ? (int'(lfsr[7:0]) + mf - 1) % mf : 0;
         vr = int'(lfsr[15:8]) % ((mf < 12 ? mf : 12) + 1);
         k = mf + 1 + int'(lfsr[11:4]) % (mf - 1);
         reg_rd(lmfc_align_pkg::ADDR_FIXED, lmfc_align_pkg::RESET_FIXED);
         reg_rd(lmfc_align_pkg::ADDR_VAR, lmfc_align_pkg::RESET_VAR);
         reg_rd(12'h300, 8'h00);
         reg_wr(lmfc_align_pkg::ADDR_LATENCY, 8'h5A);
         reg_wr(12'h458, 8'h20);
         reg_rd(lmfc_align_pkg::ADDR_LATENCY, 8'h00);
         for (int v = 0; v <= 12; v++) begin
            reg_wr(lmfc_align_pkg::ADDR_VAR, 8'(v));
            reg_rd(lmfc_align_pkg::ADDR_VAR, 8'(v));
         end
         reg_wr(lmfc_align_pkg::ADDR_VAR, 8'(vr));
         reg_wr(lmfc_align_pkg::ADDR_FIXED, 8'(fix));
         reg_rd(lmfc_align_pkg::ADDR_FIXED, 8'(fix));
         reg_req_in = '0;
         single_shot_align_arm_in = 1'b1;
         step();
         single_shot_align_arm_in = 1'b0;
         for (int i = 0; i < run; i++) begin
            sysref_in = 1'b1;
            repeat (2) step();
            sysref_in = 1'b0;
            repeat (3) step();
         end
         cmp8({7'h00, aligned_out}, 8'h00);
         sysref_in = 1'b1;
         start = 1'b1;
         t0 = cyc;
         step();
         start = 1'b0;
         repeat (k - 1) step();
         first_data_in = 1'b1;
         step();
         first_data_in = 1'b0;
         cmp8({7'h00, aligned_out}, 8'h01);
         reg_rd(lmfc_align_pkg::ADDR_LATENCY, exp_lat(k, mf));
         reg_req_in = '0;
         for (int i = 0; i < 300 && rx_idx < WORDS; i++) step();
         cmp8(8'(rx_idx), 8'(WORDS));
      end
      give_verdict();
   end
endmodule : tb
bind lmfc_delay_receive_buffer_align lmfc_align_checker chk (
   .mclk_in                  (mclk_in),
   .rst_n_in                 (rst_n_in),
   .reg_req_in               (reg_req_in),
   .reg_rdata_out            (reg_rdata_out),
   .single_shot_align_arm_in (single_shot_align_arm_in),
   .sysref_in                (sysref_in),
   .lane_ready_out           (lane_ready_out),
   .sample_valid_out         (sample_valid_out),
   .aligned_out              (aligned_out)
);
